// File: rtl/emulator_trace_break_unit.sv
// Purpose: run control, trace store, break logic and coverage of an emulator
// Assumes: CPU pulses instr_start and instr_end once per instruction, in order
// Notes: CPU samples cpu_run at instruction boundaries
`timescale 1ns/1ps
`include "emu_trace_break_map.svh"
module emulator_trace_break_unit
  import emu_trace_break_pkg::*;
#(
  parameter int PROG_AW = 14,
  parameter int TRACE_AW = 13,
  parameter int CC_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Evaluation CPU
  input wire logic instr_start,
  input wire logic instr_end,
  input wire cpu_state_t cpu_state,
  output logic cpu_run,
  output logic [8:0] trace_data_address_select,
  output logic cpu_high_speed,
  // Indicators and events
  input wire logic eprom_busy,
  output logic run_led,
  output logic stop_event
);
  localparam int PROG_N = 1 << PROG_AW;
  localparam int TRACE_N = 1 << TRACE_AW;
  localparam int ENT_W = $bits(cpu_state_t);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  attr_t attr_mem [PROG_N];
  logic cov_mem [PROG_N];
  cpu_state_t trace_mem [TRACE_N];

  emu_state_t state_r, state_nxt;
  logic [31:0] ctrl_r, rdata_r;
  logic [`STOP_W-1:0] stop_r, stop_nxt;
  logic [PROG_AW-1:0] brk_addr_r, attr_addr_r, sweep_idx_r;
  logic [15:0] pass_cnt_r, pass_left_r;
  logic [7:0] compare_r;
  logic [8:0] tdata_addr_r;
  logic [TRACE_AW-1:0] tp_r, trace_idx_r;
  logic [CC_W-1:0] cc_r;
  logic window_r, sweep_r, sweep_cov_r, fill_val_r;
  logic [`STOP_W-1:0] pend_r;
  logic cpu_run_r, run_led_r, stop_event_r, high_speed_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_cmd = wr && addr == `REG_CMD;
  wire wr_ctrl = wr && addr == `REG_CTRL;
  wire wr_stop = wr && addr == `REG_STOP;
  wire wr_pass = wr && addr == `REG_PASS_CNT;
  wire wr_attr = wr && addr == `REG_ATTR_DATA;
  wire cmd_go = wr_cmd && wdata[`CMD_GO];
  wire cmd_step = wr_cmd && wdata[`CMD_STEP];
  wire cmd_abort = wr_cmd && wdata[`CMD_ABORT];
  wire running = state_r != st_idle;
  wire [PROG_AW-1:0] fetch = cpu_state.addr[PROG_AW-1:0];
  wire attr_t cur_attr = attr_mem[fetch];
  wire [1:0] variant = ctrl_r[`CTRL_VARIANT_LO+1:`CTRL_VARIANT_LO];
  wire [13:0] limit = variant == 2'h0 ? `LIMIT_SMALL :
                      variant == 2'h1 ? `LIMIT_MID : `LIMIT_LARGE;
  wire in_window = ctrl_r[`CTRL_TRIG_MODE] ? (window_r || cur_attr.trace_start)
                                           : cur_attr.trace_en;
  wire record = instr_start && running && in_window;
  wire tp_ovf = record && (&tp_r);
  wire cc_ovf = instr_end && running && (&cc_r);
  wire pass_hit = instr_start && running && fetch == brk_addr_r;

  // ----------------------------------------
  // Break sources
  // ----------------------------------------
  logic [`STOP_W-1:0] brk_now;
  always_comb
  begin
    brk_now = '0;
    brk_now[`STOP_BP] = instr_start && cur_attr.brk && ctrl_r[`CTRL_EN_BP];
    brk_now[`STOP_TOVF] = tp_ovf && ctrl_r[`CTRL_EN_TOVF];
    brk_now[`STOP_CCOVF] = cc_ovf && ctrl_r[`CTRL_EN_CCOVF];
    brk_now[`STOP_PASS] = pass_hit && ctrl_r[`CTRL_EN_PASS] && pass_left_r <= 16'h0001;
    brk_now[`STOP_DM] = instr_start && ctrl_r[`CTRL_EN_DM] &&
                        cpu_state.dmem == compare_r[3:0];
    brk_now[`STOP_AB] = instr_start && ctrl_r[`CTRL_EN_AB] &&
                        (cpu_state.a == compare_r[7:4] || cpu_state.b == compare_r[7:4]);
    brk_now[`STOP_NAREA] = instr_start && !ctrl_r[`CTRL_EXPAND] && cpu_state.addr > limit;
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  wire any_pend = |(pend_r | brk_now);
  always_comb
  begin
    state_nxt = state_r;
    stop_nxt = wr_stop ? stop_r & ~wdata[`STOP_W-1:0] : stop_r;
    if (state_r == st_idle)
    begin
      if (cmd_go && !sweep_r)
        state_nxt = st_run;
      else if (cmd_step && !sweep_r)
        state_nxt = st_step;
    end
    else if (cmd_abort)
    begin
      state_nxt = st_idle;
      stop_nxt[`STOP_ABORT] = 1'b1;
    end
    else if (state_r == st_step && instr_end)
    begin
      state_nxt = st_idle;
      stop_nxt = stop_nxt | pend_r | brk_now;
      stop_nxt[`STOP_STEP] = 1'b1;
    end
    else if (instr_end && any_pend)
    begin
      state_nxt = st_idle;
      stop_nxt = stop_nxt | pend_r | brk_now;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_r <= st_idle;
      stop_r <= '0;
      pend_r <= '0;
      cpu_run_r <= 1'b0;
      stop_event_r <= 1'b0;
      run_led_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      stop_r <= stop_nxt;
      pend_r <= (state_nxt == st_idle || !running) ? '0 : pend_r | brk_now;
      cpu_run_r <= state_nxt != st_idle;
      stop_event_r <= running && state_nxt == st_idle;
      run_led_r <= (state_nxt != st_idle) || eprom_busy;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ctrl_r <= `CTRL_RESET;
      brk_addr_r <= '0;
      pass_cnt_r <= '0;
      compare_r <= '0;
      tdata_addr_r <= '0;
      attr_addr_r <= '0;
      trace_idx_r <= '0;
      high_speed_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata;
      if (wr && addr == `REG_BRK_ADDR)
        brk_addr_r <= wdata[PROG_AW-1:0];
      if (wr_pass)
        pass_cnt_r <= wdata[15:0];
      if (wr && addr == `REG_COMPARE)
        compare_r <= wdata[7:0];
      if (wr && addr == `REG_TDATA_ADDR)
        tdata_addr_r <= wdata[8:0];
      if (wr && addr == `REG_ATTR_ADDR)
        attr_addr_r <= wdata[PROG_AW-1:0];
      if (wr && addr == `REG_TRACE_IDX)
        trace_idx_r <= wdata[TRACE_AW-1:0];
      high_speed_r <= ctrl_r[`CTRL_HIGH_SPEED];
    end
  end

  // ----------------------------------------
  // Pass counter, cycle counter, trace pointer
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pass_left_r <= '0;
      cc_r <= '0;
      tp_r <= '0;
      window_r <= 1'b0;
    end
    else
    begin
      if (wr_pass || cmd_go || cmd_step)
        pass_left_r <= wr_pass ? wdata[15:0] : pass_cnt_r;
      else if (pass_hit && pass_left_r != 16'h0000)
        pass_left_r <= pass_left_r - 16'h0001;
      if (wr_cmd && wdata[`CMD_CLR_CC])
        cc_r <= '0;
      else if (instr_end && running)
        cc_r <= cc_r + 1'b1;
      if (wr_cmd && wdata[`CMD_CLR_TP])
        tp_r <= '0;
      else if (record)
        tp_r <= tp_r + 1'b1;
      if (instr_start && running)
      begin
        if (cur_attr.trace_stop)
          window_r <= 1'b0;
        else if (cur_attr.trace_start)
          window_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Trace store
  // ----------------------------------------
  cpu_state_t entry;
  always_comb
  begin
    entry = cpu_state;
    if (!ctrl_r[`CTRL_OPT_TRACE])
    begin
      entry.p0 = 4'h0;
      entry.p1 = 4'h0;
      entry.p4 = 4'h0;
      entry.bank_select_zero = 4'h0;
      entry.bank_select_one = 4'h0;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (record)
      trace_mem[tp_r] <= entry;
  end

  // ----------------------------------------
  // Attribute and coverage memories
  // ----------------------------------------
  // Sweep takes one cycle per address; runs are refused while it is busy
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sweep_r <= 1'b0;
      sweep_cov_r <= 1'b0;
      fill_val_r <= 1'b0;
      sweep_idx_r <= '0;
    end
    else if (sweep_r)
    begin
      sweep_idx_r <= sweep_idx_r + 1'b1;
      sweep_r <= !(&sweep_idx_r);
    end
    else if (wr_cmd && (wdata[`CMD_FILL_BP] || wdata[`CMD_CLR_COV]) && !running)
    begin
      sweep_r <= 1'b1;
      sweep_cov_r <= wdata[`CMD_CLR_COV];
      fill_val_r <= wdata[`CMD_FILL_VAL];
      sweep_idx_r <= '0;
    end
  end
  // fill, set and clear of breakpoint bits
  always_ff @(posedge ref_clk)
  begin
    if (sweep_r && !sweep_cov_r)
      attr_mem[sweep_idx_r].brk <= fill_val_r;
    else if (wr_attr)
      attr_mem[attr_addr_r] <= attr_t'(wdata[3:0]);
  end
  // set on execution, set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (instr_start && running)
      cov_mem[fetch] <= 1'b1;
    if (sweep_r && sweep_cov_r && !(instr_start && running && fetch == sweep_idx_r))
      cov_mem[sweep_idx_r] <= 1'b0;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [95:0] trace_q = {{(96 - ENT_W){1'b0}}, trace_mem[trace_idx_r]};
  wire [31:0] status_w = {28'h0, window_r, sweep_r, state_r == st_step, running};
  wire [31:0] attr_w = {27'h0, cov_mem[attr_addr_r], attr_mem[attr_addr_r]};
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (addr)
      `REG_CTRL: rd_mux = ctrl_r;
      `REG_STATUS: rd_mux = status_w;
      `REG_STOP: rd_mux = {{(32 - `STOP_W){1'b0}}, stop_r};
      `REG_BRK_ADDR: rd_mux = {{(32 - PROG_AW){1'b0}}, brk_addr_r};
      `REG_PASS_CNT: rd_mux = {16'h0, pass_cnt_r};
      `REG_COMPARE: rd_mux = {24'h0, compare_r};
      `REG_TDATA_ADDR: rd_mux = {23'h0, tdata_addr_r};
      `REG_ATTR_ADDR: rd_mux = {{(32 - PROG_AW){1'b0}}, attr_addr_r};
      `REG_ATTR_DATA: rd_mux = attr_w;
      `REG_TRACE_PTR: rd_mux = {{(32 - TRACE_AW){1'b0}}, tp_r};
      `REG_TRACE_IDX: rd_mux = {{(32 - TRACE_AW){1'b0}}, trace_idx_r};
      `REG_TRACE_W0: rd_mux = trace_q[31:0];
      `REG_TRACE_W1: rd_mux = trace_q[63:32];
      `REG_TRACE_W2: rd_mux = trace_q[95:64];
      `REG_CYCLE_CNT: rd_mux = cc_r[31:0];
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rdata_r <= '0;
    else
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
  end

  assign rdata = rdata_r;
  assign cpu_run = cpu_run_r;
  assign trace_data_address_select = tdata_addr_r;
  assign cpu_high_speed = high_speed_r;
  assign run_led = run_led_r;
  assign stop_event = stop_event_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  step_halt_a: assert property (state_r == st_step && instr_end && !cmd_abort |=> !cpu_run_r && stop_r[`STOP_STEP]) else $error("step did not halt");
  run_holds_a: assert property (state_r == st_run && !cmd_abort && !any_pend |=> cpu_run_r) else $error("run stopped without cause");
  tp_advance_a: assert property (record && !(wr_cmd && wdata[`CMD_CLR_TP]) |=> tp_r == $past(tp_r) + 1'b1) else $error("trace pointer not advanced");
  tp_wrap_a: assert property (tp_ovf && !(wr_cmd && wdata[`CMD_CLR_TP]) |=> tp_r == '0) else $error("trace pointer did not wrap");
  bp_break_a: assert property (state_r == st_run && instr_start && cur_attr.brk && ctrl_r[`CTRL_EN_BP] && !cmd_abort |=> pend_r[`STOP_BP] || stop_r[`STOP_BP]) else $error("breakpoint missed");
  cc_count_a: assert property (instr_end && running && !(wr_cmd && wdata[`CMD_CLR_CC]) |=> cc_r == $past(cc_r) + 1'b1) else $error("cycle counter stuck");
  abort_stop_a: assert property (running && cmd_abort |=> !cpu_run_r ##1 !cpu_run_r) else $error("abort ignored");
  narea_a: assert property (state_r == st_run && instr_start && !ctrl_r[`CTRL_EXPAND] && cpu_state.addr > limit && !cmd_abort |=> pend_r[`STOP_NAREA] || stop_r[`STOP_NAREA]) else $error("range break missed");
  cov_set_a: assert property (instr_start && running |=> cov_mem[$past(fetch)]) else $error("coverage bit not set");
  led_a: assert property (run_led_r == $past(state_nxt != st_idle || eprom_busy)) else $error("run indicator wrong");
  stop_a: assert property (state_r == st_run && instr_end && any_pend && !cmd_abort |=> stop_event_r && !cpu_run_r) else $error("break not reported");
  step_c: cover property (state_r == st_step ##[1:50] stop_event_r);
  bp_c: cover property (stop_event_r && stop_r[`STOP_BP]);
  wrap_c: cover property (tp_ovf);
  abort_c: cover property (running && cmd_abort);
endmodule : emulator_trace_break_unit

// File: rtl/emu_trace_break_map.svh
// Purpose: offsets, field positions and constants of the emulation control unit
// Assumes: byte offsets on a plain register port
// Notes: definitions only
`ifndef EMU_TRACE_BREAK_MAP_SVH
`define EMU_TRACE_BREAK_MAP_SVH
// Register offsets
`define REG_CMD 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_STOP 8'h0C
`define REG_BRK_ADDR 8'h10
`define REG_PASS_CNT 8'h14
`define REG_COMPARE 8'h18
`define REG_TDATA_ADDR 8'h1C
`define REG_ATTR_ADDR 8'h20
`define REG_ATTR_DATA 8'h24
`define REG_TRACE_PTR 8'h28
`define REG_TRACE_IDX 8'h2C
`define REG_TRACE_W0 8'h30
`define REG_TRACE_W1 8'h34
`define REG_TRACE_W2 8'h38
`define REG_CYCLE_CNT 8'h3C
// Command bits
`define CMD_GO 0
`define CMD_STEP 1
`define CMD_ABORT 2
`define CMD_CLR_CC 3
`define CMD_FILL_BP 4
`define CMD_FILL_VAL 5
`define CMD_CLR_COV 6
`define CMD_CLR_TP 7
// Control fields
`define CTRL_RESET 32'h0000_0000
`define CTRL_EN_BP 0
`define CTRL_EN_TOVF 1
`define CTRL_EN_CCOVF 2
`define CTRL_EN_PASS 3
`define CTRL_EN_DM 4
`define CTRL_EN_AB 5
`define CTRL_TRIG_MODE 6
`define CTRL_OPT_TRACE 7
`define CTRL_VARIANT_LO 8
`define CTRL_EXPAND 10
`define CTRL_HIGH_SPEED 11
// Stop reason bits
`define STOP_W 9
`define STOP_BP 0
`define STOP_TOVF 1
`define STOP_CCOVF 2
`define STOP_PASS 3
`define STOP_DM 4
`define STOP_AB 5
`define STOP_NAREA 6
`define STOP_ABORT 7
`define STOP_STEP 8
// Highest program address per variant
`define LIMIT_SMALL 14'h07DF
`define LIMIT_MID 14'h0FDF
`define LIMIT_LARGE 14'h1FDF
// Default CPU clock rates in Hz
`define CPU_CLK_LOW_HZ 32768
`define CPU_CLK_HIGH_HZ 700000
`endif

// File: rtl/emu_trace_break_pkg.sv
// Purpose: types of the emulation control unit
// Assumes: 4-bit CPU with 14-bit program addresses
// Notes: constants live in the map header
package emu_trace_break_pkg;
  typedef enum logic [1:0] {st_idle, st_run, st_step} emu_state_t;
  // Snapshot of the evaluation CPU at an instruction start
  typedef struct packed {
    logic [13:0] addr;
    logic [3:0] a;
    logic [3:0] b;
    logic [7:0] stack_pointer;
    logic [3:0] h;
    logic [3:0] l;
    logic carry;
    logic [3:0] p0;
    logic [3:0] p1;
    logic [3:0] p2;
    logic [3:0] p3;
    logic [3:0] p4;
    logic [3:0] bank_select_zero;
    logic [3:0] bank_select_one;
    logic [3:0] dmem;
  } cpu_state_t;
  // Per-address attributes
  typedef struct packed {
    logic trace_stop;
    logic trace_start;
    logic trace_en;
    logic brk;
  } attr_t;
endpackage : emu_trace_break_pkg

// File: tb/eval_cpu_model.sv
// Purpose: behavioural evaluation CPU facing the emulation control unit
// Assumes: unit drops cpu_run in the cycle after the closing boundary
// Notes: loops over 10H..1FH; state lines invert outside the start cycle
`timescale 1ns/1ps
module eval_cpu_model
  import emu_trace_break_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Unit side
  input wire logic cpu_run,
  input wire logic [8:0] trace_data_address_select,
  output logic instr_start,
  output logic instr_end,
  output cpu_state_t cpu_state,
  // Bench control
  input wire logic [3:0] slow,
  input wire logic load,
  input wire logic [13:0] load_pc
);
  logic [13:0] pc;
  cpu_state_t s;

  // ----------------------------------------
  // Instruction loop
  // ----------------------------------------
  // A started instruction always completes, as on the real core
  initial
  begin
    instr_start = 1'b0;
    instr_end = 1'b0;
    pc = 14'h0000;
    cpu_state = '1;
    forever
    begin
      @(posedge ref_clk);
      if (load)
        pc = load_pc;
      if (rstn && cpu_run)
      begin
        s = {pc, pc[3:0], pc[7:4], pc[7:0] ^ 8'hA5, 4'h3, 4'hC, pc[0], 4'h1, 4'h2, 4'h3,
             4'h4, 4'h5, 4'h6, 4'h9, pc[3:0] ^ trace_data_address_select[3:0]};
        instr_start <= 1'b1;
        cpu_state <= s;
        @(posedge ref_clk);
        instr_start <= 1'b0;
        cpu_state <= ~s;
        repeat (slow) @(posedge ref_clk);
        instr_end <= 1'b1;
        @(posedge ref_clk);
        instr_end <= 1'b0;
        pc = (pc == 14'h001F) ? 14'h0010 : pc + 14'h0001;
      end
    end
  end
endmodule : eval_cpu_model

// File: tb/emulator_trace_break_unit_tb_top.sv
// Purpose: self-checking bench of the emulation control unit
// Assumes: trace pointer shortened to 4 bits, so 16 entries
// Notes: rows drive free runs; reset, sweeps and step by hand
`timescale 1ns/1ps
`include "emu_trace_break_map.svh"
module emulator_trace_break_unit_tb_top
  import emu_trace_break_pkg::*;
;
  typedef struct packed {
    logic [13:0] pc;
    logic [11:0] ctrl;
    logic [7:0] aux_a;
    logic [7:0] aux_d;
    logic [7:0] abort_at;
    logic [8:0] stop;
    logic [7:0] cnt;
  } run_row_t;
  localparam run_row_t ROWS [10] = '{
    '{14'h0010, 12'h001, 8'h00, 8'h00, 8'h00, 9'h001, 8'h09},
    '{14'h0010, 12'h042, 8'h00, 8'h00, 8'h00, 9'h002, 8'h35},
    '{14'h0010, 12'h008, `REG_PASS_CNT, 8'h03, 8'h00, 9'h008, 8'h23},
    '{14'h0010, 12'h020, `REG_COMPARE, 8'h50, 8'h00, 9'h020, 8'h06},
    '{14'h0010, 12'h010, `REG_TDATA_ADDR, 8'h0C, 8'h00, 9'h010, 8'h0D},
    '{14'h07DE, 12'h000, 8'h00, 8'h00, 8'h00, 9'h040, 8'h03},
    '{14'h07DE, 12'h400, 8'h00, 8'h00, 8'h0C, 9'h080, 8'h00},
    '{14'h0FDE, 12'h100, 8'h00, 8'h00, 8'h00, 9'h040, 8'h03},
    '{14'h1FDE, 12'h200, 8'h00, 8'h00, 8'h00, 9'h040, 8'h03},
    '{14'h0010, 12'h082, 8'h00, 8'h00, 8'h00, 9'h002, 8'h10}
  };
  logic ref_clk, rstn, wr, rd, instr_start, instr_end, cpu_run, cpu_high_speed;
  logic eprom_busy, run_led, stop_event, load;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [8:0] tdsel;
  logic [3:0] slow;
  logic [13:0] load_pc;
  cpu_state_t cpu_state;
  int errors, num_checks, n_exec;

  emulator_trace_break_unit #(.TRACE_AW(4)) uut (.ref_clk(ref_clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .instr_start(instr_start), .instr_end(instr_end), .cpu_state(cpu_state),
    .cpu_run(cpu_run), .trace_data_address_select(tdsel),
    .cpu_high_speed(cpu_high_speed), .eprom_busy(eprom_busy), .run_led(run_led),
    .stop_event(stop_event));
  eval_cpu_model cpu (.ref_clk(ref_clk), .rstn(rstn), .cpu_run(cpu_run),
    .trace_data_address_select(tdsel), .instr_start(instr_start),
    .instr_end(instr_end), .cpu_state(cpu_state), .slow(slow), .load(load),
    .load_pc(load_pc));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (instr_start === 1'b1)
      n_exec <= n_exec + 1;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask : rd_reg

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask : chk_reg

  task automatic sweep(input logic [31:0] cmd);
    logic [31:0] v;
    wr_reg(`REG_CMD, cmd);
    v = 32'h4;
    for (int k = 0; k < 20000 && v[2] !== 1'b0; k++)
      rd_reg(`REG_STATUS, v);
    check("sweep busy", {31'h0, v[2]}, 32'h0);
  endtask : sweep

  // ----------------------------------------
  // Run tasks
  // ----------------------------------------
  task automatic prep(input logic [13:0] pc, input logic [11:0] ctrl);
    wr_reg(`REG_STOP, 32'h1FF);
    wr_reg(`REG_CMD, 32'h88);
    wr_reg(`REG_CTRL, {20'h0, ctrl});
    @(posedge ref_clk);
    load <= 1'b1;
    load_pc <= pc;
    @(posedge ref_clk);
    load <= 1'b0;
    n_exec = 0;
  endtask : prep

  task automatic end_run(input logic [8:0] stop, input logic [7:0] cnt);
    for (int k = 0; k < 1000 && stop_event !== 1'b1; k++)
      @(negedge ref_clk);
    check("stop_event", {31'h0, stop_event}, 32'h1);
    check("cpu_run stop", {31'h0, cpu_run}, 32'h0);
    chk_reg(`REG_STOP, {23'h0, stop});
    if (cnt != 8'h00)
    begin
      check("executed", 32'(n_exec), {24'h0, cnt});
      chk_reg(`REG_CYCLE_CNT, {24'h0, cnt});
    end
  endtask : end_run

  task automatic run_row(input run_row_t r);
    prep(r.pc, r.ctrl);
    wr_reg(r.aux_a, {24'h0, r.aux_d});
    wr_reg(`REG_CMD, 32'h1);
    repeat (3) @(negedge ref_clk);
    check("cpu_run go", {31'h0, cpu_run}, 32'h1);
    check("run_led go", {31'h0, run_led}, 32'h1);
    if (r.abort_at != 8'h00)
    begin
      repeat (r.abort_at) @(posedge ref_clk);
      wr_reg(`REG_CMD, 32'h4);
    end
    end_run(r.stop, r.cnt);
  endtask : run_row

  // First entry always holds address 10H with data select 0CH
  task automatic chk_entry(input logic opt);
    cpu_state_t s;
    s = {14'h0010, 4'h0, 4'h1, 8'hB5, 4'h3, 4'hC, 1'b0, opt ? 8'h12 : 8'h00, 8'h34,
         opt ? 12'h569 : 12'h000, 4'hC};
    wr_reg(`REG_TRACE_IDX, 32'h0);
    chk_reg(`REG_TRACE_W0, s[31:0]);
    chk_reg(`REG_TRACE_W1, s[63:32]);
    chk_reg(`REG_TRACE_W2, {25'h0, s[70:64]});
    chk_reg(`REG_TRACE_PTR, 32'h0);
  endtask : chk_entry

  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    {wr, rd, eprom_busy, load} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    load_pc = 14'h0000;
    slow = 4'h2;
    repeat (15) @(posedge ref_clk);
    @(negedge ref_clk);
    check("cpu_run reset", {31'h0, cpu_run}, 32'h0);
    check("run_led reset", {31'h0, run_led}, 32'h0);
    check("rdata reset", rdata, 32'h0);
    @(posedge ref_clk);
    rstn <= 1'b1;
    chk_reg(`REG_CTRL, 32'h0);
    chk_reg(8'h40, 32'h0);
    sweep(32'h30);
    wr_reg(`REG_ATTR_ADDR, 32'h3000);
    rd_reg(`REG_ATTR_DATA, d);
    check("fill one", {31'h0, d[0]}, 32'h1);
    sweep(32'h10);
    rd_reg(`REG_ATTR_DATA, d);
    check("fill zero", {31'h0, d[0]}, 32'h0);
    sweep(32'h40);
    for (int i = 16; i < 48; i++)
    begin
      wr_reg(`REG_ATTR_ADDR, 32'(i));
      wr_reg(`REG_ATTR_DATA, {28'h0, i == 24, i == 20, i < 32, i == 24});
    end
    // Clean attributes around each variant limit
    for (int i = 0; i < 48; i++)
    begin
      wr_reg(`REG_ATTR_ADDR, 32'(i < 16 ? 16'h07D8 + i : i < 32 ? 16'h0FC8 + i : 16'h1FB8 + i));
      wr_reg(`REG_ATTR_DATA, 32'h0);
    end
    wr_reg(`REG_BRK_ADDR, 32'h12);
    foreach (ROWS[j])
      run_row(ROWS[j]);
    check("data select", {23'h0, tdsel}, 32'h00C);
    chk_entry(1'b1);
    run_row('{14'h0010, 12'h002, 8'h00, 8'h00, 8'h00, 9'h002, 8'h10});
    chk_entry(1'b0);
    slow <= 4'h0;
    prep(14'h0020, 12'h000);
    wr_reg(`REG_CMD, 32'h2);
    end_run(9'h100, 8'h01);
    slow <= 4'h2;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(`REG_ATTR_ADDR, i == 0 ? 32'h10 : i == 1 ? 32'h18 : i == 2 ? 32'h20 : 32'h2F);
      chk_reg(`REG_ATTR_DATA, i == 0 ? 32'h12 : i == 1 ? 32'h1B : i == 2 ? 32'h10 : 32'h0);
    end
    @(posedge ref_clk);
    eprom_busy <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check("run_led busy", {31'h0, run_led}, 32'h1);
    @(posedge ref_clk);
    eprom_busy <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("run_led idle", {31'h0, run_led}, 32'h0);
    wr_reg(`REG_CTRL, 32'h800);
    repeat (2) @(negedge ref_clk);
    check("high speed", {31'h0, cpu_high_speed}, 32'h1);
    // Reset in mid-run, held three edges
    prep(14'h0010, 12'h000);
    wr_reg(`REG_CMD, 32'h1);
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check("cpu_run mid reset", {31'h0, cpu_run}, 32'h0);
    check("run_led mid reset", {31'h0, run_led}, 32'h0);
    chk_reg(`REG_CTRL, 32'h0);
    chk_reg(`REG_STOP, 32'h0);
    tally_and_finish();
  end

  initial
  begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule : emulator_trace_break_unit_tb_top
